/* design/irpc_codec.sv */
/*
 * Infrared pulse encoder and decoder between a serial port and an infrared
 * transceiver, with its three control registers and a status register.
 * Assumes baud_edge marks each rising edge of the serial port's baud clock,
 * baud_x16 ticks sixteen times per bit, and all inputs are synchronous.
 */
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "irpc_consts.svh"

module irpc_codec #(
    parameter int BIT_TICKS = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial port side
    input wire logic [1:0] comm_mode_select,
    input wire logic baud_edge,
    input wire logic baud_x16,
    input wire logic uart_txd,
    output logic uart_rxd,
    // Transceiver and event side
    output logic ir_txd,
    input wire logic ir_rxd,
    input wire logic ev_in
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    if (BIT_TICKS != 16) begin : g_bad_ticks
        $error("irpc_codec: BIT_TICKS must be 16");
    end

    irpc_pkg::irpc_state_t s_reg;
    irpc_pkg::irpc_state_t s_next;

    logic ir_mode;
    logic bypass;
    logic fixed_len;
    logic src;
    logic wr_hit;
    logic [7:0] idx;
    logic [6:0] run_next;

    assign ir_mode = (comm_mode_select == `IRPC_MODE_IR);
    assign bypass = (s_reg.tx_pulse_len == `IRPC_TX_PULSE_LEN_BYPASS);
    assign fixed_len = !bypass && (s_reg.tx_pulse_len != `IRPC_TX_PULSE_LEN_FRAC);
    assign idx = reg_addr[9:2];
    assign wr_hit = reg_wr && (reg_addr[1:0] == 2'h0);
    assign src = s_reg.evt_en ? ev_in : ir_rxd;
    assign run_next = (src == s_reg.src_prev) ?
        ((s_reg.run_cnt == 7'h7F) ? s_reg.run_cnt : s_reg.run_cnt + 7'h01) : 7'h00;

    always_comb begin
        s_next = s_reg;

        // --------------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------------
        if (wr_hit) begin
            case (idx)
                `IRPC_IDX_EVT: begin
                    s_next.evt_en = reg_wdata[`IRPC_EVT_EN_BIT];
                end
                `IRPC_IDX_TX_PULSE_LEN: begin
                    s_next.tx_pulse_len = reg_wdata;
                end
                `IRPC_IDX_RX_PULSE_LEN: begin
                    s_next.rx_pulse_len = reg_wdata[`IRPC_RX_PULSE_LEN_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Register reads, data valid in the following cycle only
        // --------------------------------------------------------------------
        s_next.rdata = 8'h00;
        if (reg_rd && (reg_addr[1:0] == 2'h0)) begin
            case (idx)
                `IRPC_IDX_EVT: begin
                    s_next.rdata = {7'h00, s_reg.evt_en};
                end
                `IRPC_IDX_TX_PULSE_LEN: begin
                    s_next.rdata = s_reg.tx_pulse_len;
                end
                `IRPC_IDX_RX_PULSE_LEN: begin
                    s_next.rdata = {1'b0, s_reg.rx_pulse_len};
                end
                `IRPC_IDX_STAT: begin
                    s_next.rdata = {4'h0, s_reg.rx_out, s_reg.filt_val,
                                    s_reg.tx_out, ir_mode};
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Encoder
        // --------------------------------------------------------------------
        if (ir_mode && !bypass) begin
            if (baud_edge && !uart_txd) begin
                s_next.tx_cnt = fixed_len ? s_reg.tx_pulse_len : `IRPC_FRAC_TICKS;
            end else if (s_reg.tx_cnt != 8'h00 && (fixed_len || baud_x16)) begin
                s_next.tx_cnt = s_reg.tx_cnt - 8'h01;
            end
            s_next.tx_out = (s_next.tx_cnt != 8'h00);
        end else begin
            s_next.tx_cnt = 8'h00;
            s_next.tx_out = uart_txd;
        end

        // --------------------------------------------------------------------
        // Receive filter and decoder
        // --------------------------------------------------------------------
        s_next.src_prev = src;
        s_next.run_cnt = run_next;
        if (run_next >= s_reg.rx_pulse_len) begin
            s_next.filt_val = src;
        end
        if (ir_mode && !bypass) begin
            // A pulse stretches to one low bit on the serial side.
            if (s_next.filt_val && !s_reg.filt_val) begin
                s_next.rx_cnt = `IRPC_BIT_TICKS;
            end else if (s_reg.rx_cnt != 5'h00 && baud_x16) begin
                s_next.rx_cnt = s_reg.rx_cnt - 5'h01;
            end
            s_next.rx_out = (s_next.rx_cnt == 5'h00);
        end else begin
            s_next.rx_cnt = 5'h00;
            s_next.rx_out = src;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.evt_en <= `IRPC_RST_EVT;
            s_reg.tx_pulse_len <= `IRPC_RST_TX_PULSE_LEN;
            s_reg.rx_pulse_len <= `IRPC_RST_RX_PULSE_LEN;
            s_reg.tx_out <= 1'b1;
            s_reg.src_prev <= 1'b1;
            s_reg.filt_val <= 1'b1;
            s_reg.rx_out <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata;
    assign ir_txd = s_reg.tx_out;
    assign uart_rxd = s_reg.rx_out;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_bypass_tx: assert property (ir_mode && bypass |=> ir_txd == $past(uart_txd))
        else $error("bypass transmit not passed through");
    a_nonir_tx: assert property (!ir_mode |=> ir_txd == $past(uart_txd))
        else $error("transmit coded outside infrared mode");
    a_fixed_start: assert property (ir_mode && fixed_len && baud_edge && !uart_txd
        |=> ir_txd)
        else $error("fixed pulse did not start");
    a_fixed_two: assert property (ir_mode && s_reg.tx_pulse_len == 8'h02
        && baud_edge && !uart_txd ##1 !baud_edge |=> ir_txd ##1 !ir_txd)
        else $error("two-clock pulse has wrong length");
    a_edge_only: assert property (ir_mode && !bypass && !baud_edge
        && s_reg.tx_cnt == 8'h00 |=> !ir_txd)
        else $error("pulse started off baud edge");
    a_frac_start: assert property (ir_mode && s_reg.tx_pulse_len == 8'h00
        && baud_edge && !uart_txd |=> s_reg.tx_cnt == 8'h03 && ir_txd)
        else $error("fractional pulse not loaded");
    a_nofilter: assert property (s_reg.rx_pulse_len == 7'h00 |=> s_reg.filt_val == $past(src))
        else $error("unfiltered input not passed");
    a_filter_hold: assert property (src != s_reg.src_prev && s_reg.rx_pulse_len != 7'h00
        |=> s_reg.filt_val == $past(s_reg.filt_val))
        else $error("filter accepted a single sample");
    a_filter_take: assert property ((s_reg.rx_pulse_len == 7'h02 && src && !reg_wr) [*3]
        |=> s_reg.filt_val)
        else $error("filter missed three equal samples");
    a_event_route: assert property (s_reg.evt_en && !ir_mode |=> uart_rxd == $past(ev_in))
        else $error("event input not routed");
    a_rx_pulse_len_bit7: assert property (reg_rd && reg_addr == {`IRPC_IDX_RX_PULSE_LEN, 2'h0}
        |=> !reg_rdata[7])
        else $error("receive length bit 7 not zero");

    // ------------------------------------------------------------------------
    // Register port checks
    // ------------------------------------------------------------------------
    // Read data must not linger, or a late sampler would take a stale byte.
    // read data once
    a_rdata_once: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stood past its cycle");
    a_tx_pulse_len_write: assert property (reg_wr && reg_addr == {`IRPC_IDX_TX_PULSE_LEN, 2'h0}
        |=> s_reg.tx_pulse_len == $past(reg_wdata))
        else $error("transmit length write lost");
    a_rx_pulse_len_write: assert property (reg_wr && reg_addr == {`IRPC_IDX_RX_PULSE_LEN, 2'h0}
        |=> s_reg.rx_pulse_len == $past(reg_wdata[`IRPC_RX_PULSE_LEN_W-1:0]))
        else $error("receive length write lost");
    a_evt_write: assert property (reg_wr && reg_addr == {`IRPC_IDX_EVT, 2'h0}
        |=> s_reg.evt_en == $past(reg_wdata[`IRPC_EVT_EN_BIT]))
        else $error("event enable write lost");
    a_evt_read: assert property (reg_rd && reg_addr == {`IRPC_IDX_EVT, 2'h0}
        |=> reg_rdata[7:1] == 7'h00)
        else $error("event control upper bits not zero");
    a_stat_mode: assert property (reg_rd && reg_addr == {`IRPC_IDX_STAT, 2'h0}
        |=> reg_rdata[0] == $past(ir_mode))
        else $error("status mode bit wrong");

    // ------------------------------------------------------------------------
    // Pulse start and end checks
    // ------------------------------------------------------------------------
    // A zero bit on a baud edge reloads the count, so each end check
    // leaves that case out; the reload is covered by the start checks.
    // fixed pulse ends
    a_fixed_end: assert property (ir_mode && fixed_len && s_reg.tx_cnt == 8'h01
        && !(baud_edge && !uart_txd) |=> !ir_txd)
        else $error("fixed pulse ran long");
    a_frac_end: assert property (ir_mode && !bypass && !fixed_len
        && s_reg.tx_cnt == 8'h01 && baud_x16
        && !(baud_edge && !uart_txd) |=> !ir_txd)
        else $error("fractional pulse ran long");
    a_one_dark: assert property (ir_mode && !bypass && baud_edge && uart_txd
        && s_reg.tx_cnt == 8'h00 |=> !ir_txd)
        else $error("pulse sent for a one bit");

    // ------------------------------------------------------------------------
    // Receive path checks
    // ------------------------------------------------------------------------
    // A decoded pulse is held low for a whole bit so the serial receiver
    // can sample it in the middle of the bit.
    // stretch holds low
    a_rx_stretch: assert property (ir_mode && !bypass && s_reg.rx_cnt > 5'h01
        |=> !uart_rxd)
        else $error("decoded bit ended early");
    a_bypass_rx: assert property (ir_mode && bypass |=> uart_rxd == $past(src))
        else $error("bypass receive not passed through");
    a_nonir_rx: assert property (!ir_mode |=> uart_rxd == $past(src))
        else $error("receive decoded outside infrared mode");
    a_pin_cut: assert property (s_reg.evt_en && !ir_mode && ir_rxd && !ev_in
        |=> !uart_rxd)
        else $error("receive pin not disconnected");

    c_fixed_pulse: cover property (ir_mode && fixed_len && $rose(ir_txd));
    c_frac_pulse: cover property (ir_mode && s_reg.tx_pulse_len == 8'h00 && $fell(ir_txd));
    c_filter_take: cover property (s_reg.rx_pulse_len != 7'h00 && $changed(s_reg.filt_val));
    c_event_rx: cover property (s_reg.evt_en && ir_mode && $fell(uart_rxd));
    c_bypass_pass: cover property (ir_mode && bypass && $changed(ir_txd));

endmodule : irpc_codec
`default_nettype wire

/* design/irpc_consts.svh */
/*
 * Register indices, field positions, reset values and coding constants for the
 * infrared pulse codec. Assumes it is included by bare name from design files.
 */
`ifndef IRPC_CONSTS_SVH
`define IRPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------------
`define IRPC_IDX_EVT 8'h0C
`define IRPC_IDX_TX_PULSE_LEN 8'h0D
`define IRPC_IDX_RX_PULSE_LEN 8'h0E
`define IRPC_IDX_STAT 8'h0F

// ----------------------------------------------------------------------------
// Fields, reset values and codes
// ----------------------------------------------------------------------------
`define IRPC_EVT_EN_BIT 0
`define IRPC_RX_PULSE_LEN_W 7
`define IRPC_RST_EVT 1'h0
`define IRPC_RST_TX_PULSE_LEN 8'h00
`define IRPC_RST_RX_PULSE_LEN 7'h00
`define IRPC_TX_PULSE_LEN_FRAC 8'h00
`define IRPC_TX_PULSE_LEN_BYPASS 8'hFF
`define IRPC_FRAC_TICKS 8'h03
`define IRPC_BIT_TICKS 5'h10
`define IRPC_MODE_IR 2'h2

`endif

/* design/irpc_pkg.sv */
/*
 * Types of the infrared pulse codec: communication mode codes and the
 * packed state of the codec. Assumes irpc_consts.svh sits beside it.
 */
package irpc_pkg;

    typedef enum logic [1:0] {
        IRPC_MODE_ASYNC = 2'h0,
        IRPC_MODE_SYNC = 2'h1,
        IRPC_MODE_INFRARED = 2'h2,
        IRPC_MODE_SPI = 2'h3
    } irpc_mode_t;

    typedef struct packed {
        logic evt_en;
        logic [7:0] tx_pulse_len;
        logic [6:0] rx_pulse_len;
        logic [7:0] rdata;
        logic [7:0] tx_cnt;
        logic tx_out;
        logic src_prev;
        logic [6:0] run_cnt;
        logic filt_val;
        logic [4:0] rx_cnt;
        logic rx_out;
    } irpc_state_t;

endpackage : irpc_pkg

/* bench/irpc_xcvr_model.sv */
/* Transceiver optics and event channel model for the infrared codec bench.
   Assumes pulse() is called just after a rising clock edge. */
`timescale 1ns/1ns
`default_nettype none
module irpc_xcvr_model (
    // Clock
    input wire logic sys_clk,
    // Light and event lines
    output logic ir_rxd,
    output logic ev_in
);
    // Both lines rest low, as dark optics pull the receiver down.
    initial begin
        ir_rxd = 1'h0;
        ev_in = 1'h0;
    end
    // --------------------------------------------------------------------
    // Pulse source
    // --------------------------------------------------------------------
    // event or light
    task automatic pulse(input logic evt, input int len);
        if (evt) begin
            ev_in <= 1'h1;
        end else begin
            ir_rxd <= 1'h1;
        end
        repeat (len) @(posedge sys_clk);
        ev_in <= 1'h0;
        ir_rxd <= 1'h0;
    endtask : pulse
endmodule : irpc_xcvr_model
`default_nettype wire

/* bench/irpc_codec_tb.sv */
/* Self-checking bench for the infrared pulse codec.
   Assumes irpc_consts.svh is on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "irpc_consts.svh"
module irpc_codec_tb;
    logic sys_clk, rst_n, reg_wr, reg_rd, baud_edge, baud_x16, uart_txd, uart_rxd;
    logic ir_txd, ir_rxd, ev_in;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] comm_mode_select;
    int err_count, tests_run, cyc, n;
    irpc_codec u_irpc_codec (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .comm_mode_select, .baud_edge, .baud_x16, .uart_txd, .uart_rxd,
        .ir_txd, .ir_rxd, .ev_in);
    irpc_xcvr_model u_irpc_xcvr_model (.sys_clk, .ir_rxd, .ev_in);
    // --------------------------------------------------------------------
    // Baud ticks and hang guard
    // --------------------------------------------------------------------
    // A bit lasts 64 clocks, so a sixteenth is four clocks.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        baud_x16 <= (cyc % 4 == 3);
        baud_edge <= (cyc % 64 == 63);
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'h1;
        reg_addr <= {idx, 2'h0};
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rdck(input logic [7:0] idx, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'h1;
        reg_addr <= {idx, 2'h0};
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(negedge sys_clk);
        check(reg_rdata, exp);
        @(negedge sys_clk);
        check(reg_rdata, 8'h00);
    endtask : rdck
    task automatic tx_len();
        uart_txd <= 1'h0;
        do @(negedge sys_clk); while (baud_edge !== 1'h1);
        @(posedge sys_clk);
        uart_txd <= 1'h1;
        n = 0;
        @(negedge sys_clk);
        check(ir_txd, 1'h1);
        while (ir_txd === 1'h1 && n < 300) begin
            n++;
            @(negedge sys_clk);
        end
    endtask : tx_len
    task automatic rx_try(input logic evt, input int len, input logic exp);
        logic s;
        s = 1'h0;
        @(posedge sys_clk);
        u_irpc_xcvr_model.pulse(evt, len);
        repeat (12) begin
            @(negedge sys_clk);
            s |= (uart_rxd === 1'h0);
        end
        check(s, exp);
        repeat (80) @(posedge sys_clk);
    endtask : rx_try
    task automatic t_regs();
        rdck(`IRPC_IDX_TX_PULSE_LEN, 8'h00);
        wr(`IRPC_IDX_RX_PULSE_LEN, 8'hFF);
        rdck(`IRPC_IDX_RX_PULSE_LEN, 8'h7F);
        wr(`IRPC_IDX_EVT, 8'hFF);
        rdck(`IRPC_IDX_EVT, 8'h01);
        wr(8'h20, 8'hFF);
        rdck(8'h20, 8'h00);
        wr(`IRPC_IDX_EVT, 8'h00);
    endtask : t_regs
    task automatic t_tx();
        logic [7:0] lens [4] = '{8'h01, 8'h02, 8'hFE, 8'h00};
        logic [7:0] want [4] = '{8'h01, 8'h02, 8'hFE, 8'h0C};
        comm_mode_select <= `IRPC_MODE_IR;
        foreach (lens[i]) begin
            wr(`IRPC_IDX_TX_PULSE_LEN, lens[i]);
            tx_len();
            check(8'(n), want[i]);
        end
    endtask : t_tx
    task automatic t_pass();
        for (int m = 0; m < 4; m++) begin
            wr(`IRPC_IDX_TX_PULSE_LEN, (m == 2) ? 8'hFF : 8'h00);
            comm_mode_select <= 2'(m);
            uart_txd <= 1'h1;
            repeat (3) @(posedge sys_clk);
            uart_txd <= 1'h0;
            @(negedge sys_clk);
            check(ir_txd, 1'h1);
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            check({ir_txd, uart_rxd}, 8'h00);
        end
    endtask : t_pass
    task automatic t_rx();
        comm_mode_select <= `IRPC_MODE_IR;
        uart_txd <= 1'h1;
        wr(`IRPC_IDX_TX_PULSE_LEN, 8'h00);
        wr(`IRPC_IDX_RX_PULSE_LEN, 8'h02);
        repeat (80) @(posedge sys_clk);
        rdck(`IRPC_IDX_STAT, 8'h09);
        rx_try(1'h0, 2, 1'h0);
        rx_try(1'h0, 3, 1'h1);
        wr(`IRPC_IDX_RX_PULSE_LEN, 8'h00);
        rx_try(1'h0, 1, 1'h1);
        wr(`IRPC_IDX_EVT, 8'h01);
        rx_try(1'h0, 5, 1'h0);
        rx_try(1'h1, 5, 1'h1);
    endtask : t_rx
    task automatic t_reset();
        wr(`IRPC_IDX_TX_PULSE_LEN, 8'h05);
        @(posedge sys_clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'h1;
        rdck(`IRPC_IDX_TX_PULSE_LEN, 8'h00);
        rdck(`IRPC_IDX_EVT, 8'h00);
    endtask : t_reset
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 10'h000;
        reg_wdata = 8'h00;
        comm_mode_select = 2'h0;
        baud_edge = 1'h0;
        baud_x16 = 1'h0;
        uart_txd = 1'h1;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'h1;
        t_regs();
        t_tx();
        t_pass();
        t_rx();
        t_reset();
        end_sim();
    end
endmodule : irpc_codec_tb
`default_nettype wire
